// *** verilog/thermo_host.sv ***
// Two-wire bus master that drives the thermometer through its serial pins
// Overview of operation
// - Master makes every clock, START, STOP
// - START is data falling while clock high
// - STOP is data rising while clock high
// - Data changes only while clock low
// - Eight-bit bytes each with acknowledge bit
// - Receiver pulls data low on ack clock
// - Master leaves last read byte unacknowledged
// - Repeated START ends and begins transfer
// - Write: control, command, then data bytes
// - Read: command, repeated START, control read
//
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
module thermo_host #(
  parameter int         QUARTER   = thermo_host_pkg::QUARTER_CYC,
  parameter logic [3:0] TYPE_CODE = thermo_host_pkg::DEVICE_TYPE_CODE
) (
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_scl,
  output logic             o_scl,
  output logic             o_scl_oe,
  input  wire logic        i_sda,
  output logic             o_sda,
  output logic             o_sda_oe
);
  import thermo_host_pkg::*;

  typedef enum {ST_IDLE, ST_START, ST_BYTE, ST_ACK, ST_RESTART, ST_STOP} state_t;
  typedef enum {PH_CTRL_W, PH_CMD, PH_WDATA, PH_CTRL_R, PH_RDATA} phase_t;

  // ==========================================================
  // Pin synchronisers
  logic [1:0] sda_sync_q;
  logic [1:0] scl_sync_q;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sda_sync_q <= 2'b11;
      scl_sync_q <= 2'b11;
    end else begin
      sda_sync_q <= {sda_sync_q[0], i_sda};
      scl_sync_q <= {scl_sync_q[0], i_scl};
    end
  end
  logic sda_in;
  logic scl_in;
  assign sda_in = sda_sync_q[1];
  assign scl_in = scl_sync_q[1];

  // ==========================================================
  // APB slave
  logic [31:0] ctrl_q;
  logic [15:0] wdata_q;
  logic [15:0] rdata_q;
  logic        busy_q;
  logic        nack_q;
  logic        done_q;
  logic        wr_en;
  logic        go;
  assign o_pready  = 1'b1;
  assign o_pslverr = 1'b0;
  assign wr_en = i_psel && i_penable && i_pwrite;
  assign go = wr_en && i_paddr == REG_CTRL && i_pwdata[CTRL_GO_BIT] && !busy_q;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl_q  <= RESET_ZERO;
      wdata_q <= RESET_ZERO[15:0];
    end else if (wr_en && !busy_q) begin
      if (i_paddr == REG_CTRL) begin
        ctrl_q <= i_pwdata;
      end
      if (i_paddr == REG_WDATA) begin
        wdata_q <= i_pwdata[15:0];
      end
    end
  end

  always_comb begin
    case (i_paddr)
      REG_CTRL:   o_prdata = ctrl_q;
      REG_STATUS: o_prdata = {29'h0, done_q, nack_q, busy_q};
      REG_RDATA:  o_prdata = {16'h0, rdata_q};
      REG_WDATA:  o_prdata = {16'h0, wdata_q};
      default:    o_prdata = 32'h0000_0000;
    endcase
  end

  // ==========================================================
  // Serial engine
  logic tick;
  quarter_tick #(.DIV(QUARTER)) u_tick (
    .i_clk   (i_clk),
    .i_arst_n(i_arst_n),
    .i_run   (busy_q),
    .o_tick  (tick)
  );

  state_t     st_q;
  phase_t     ph_q;
  logic [1:0] qtr_q;
  logic [2:0] bit_q;
  logic [7:0] sh_q;
  logic [1:0] nbytes_q;
  logic [1:0] bcnt_q;
  logic       scl_q;
  logic       sda_q;
  logic       is_read;
  logic [7:0] ctrl_byte_w;
  logic       last_rd;

  function automatic logic [7:0] ctrl_byte(input logic [3:0] code, input logic [2:0] sel,
                                           input logic rd);
    ctrl_byte = {code, sel, rd};
  endfunction : ctrl_byte

  assign is_read     = ctrl_q[CTRL_READ_BIT];
  assign ctrl_byte_w = ctrl_byte(TYPE_CODE, ctrl_q[CTRL_SEL_LSB +: 3], 1'b0);
  assign last_rd     = (bcnt_q + 2'd1 == nbytes_q);

  // Clock stretching by the far end is honoured: the high quarter waits for the line
  logic scl_wait;
  assign scl_wait = scl_q && !scl_in;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_q     <= ST_IDLE;
      ph_q     <= PH_CTRL_W;
      qtr_q    <= 2'd0;
      bit_q    <= 3'd7;
      sh_q     <= 8'h00;
      nbytes_q <= 2'd0;
      bcnt_q   <= 2'd0;
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
      busy_q   <= 1'b0;
      nack_q   <= 1'b0;
      done_q   <= 1'b0;
      rdata_q  <= 16'h0000;
    end else if (go) begin
      busy_q   <= 1'b1;
      done_q   <= 1'b0;
      nack_q   <= 1'b0;
      st_q     <= ST_START;
      ph_q     <= PH_CTRL_W;
      qtr_q    <= 2'd0;
      bcnt_q   <= 2'd0;
      nbytes_q <= i_pwdata[CTRL_NDATA_LSB +: 2];
    end else if (tick && !scl_wait) begin
      qtr_q <= qtr_q + 2'd1;
      case (st_q)
        ST_START: begin
          // Bus idle first, then data falls while clock high
          if (qtr_q == 2'd0 && !(scl_in && sda_in)) begin
            qtr_q <= 2'd0;
          end else if (qtr_q == 2'd1) begin
            sda_q <= 1'b0;
          end else if (qtr_q == 2'd3) begin
            scl_q <= 1'b0;
            sh_q  <= (ph_q == PH_CTRL_R) ? (ctrl_byte_w | 8'h01) : ctrl_byte_w;
            bit_q <= 3'd7;
            st_q  <= ST_BYTE;
          end
        end
        ST_BYTE: begin
          // Data moves in the low half, sampled mid-high
          case (qtr_q)
            2'd0: sda_q <= (ph_q == PH_RDATA) ? 1'b1 : sh_q[7];
            2'd1: scl_q <= 1'b1;
            2'd2: if (ph_q == PH_RDATA) sh_q <= {sh_q[6:0], sda_in};
            default: begin
              scl_q <= 1'b0;
              if (ph_q != PH_RDATA) sh_q <= {sh_q[6:0], 1'b0};
              bit_q <= bit_q - 3'd1;
              if (bit_q == 3'd0) st_q <= ST_ACK;
            end
          endcase
        end
        ST_ACK: begin
          case (qtr_q)
            2'd0: sda_q <= (ph_q == PH_RDATA) ? last_rd : 1'b1;
            2'd1: scl_q <= 1'b1;
            2'd2: begin
              if (ph_q != PH_RDATA && sda_in) begin
                nack_q <= 1'b1;
              end
              if (ph_q == PH_RDATA) begin
                rdata_q <= {rdata_q[7:0], sh_q};
              end
            end
            default: begin
              scl_q <= 1'b0;
              bit_q <= 3'd7;
              if (nack_q) begin
                st_q <= ST_STOP;
              end else begin
                case (ph_q)
                  PH_CTRL_W: begin
                    ph_q <= PH_CMD;
                    sh_q <= ctrl_q[CTRL_CMD_LSB +: 8];
                    st_q <= ST_BYTE;
                  end
                  PH_CMD: begin
                    if (nbytes_q == 2'd0) begin
                      st_q <= ST_STOP;
                    end else if (is_read) begin
                      ph_q <= PH_CTRL_R;
                      st_q <= ST_RESTART;
                    end else begin
                      ph_q <= PH_WDATA;
                      sh_q <= (nbytes_q == 2'd2) ? wdata_q[15:8] : wdata_q[7:0];
                      st_q <= ST_BYTE;
                    end
                  end
                  PH_WDATA, PH_RDATA: begin
                    bcnt_q <= bcnt_q + 2'd1;
                    sh_q   <= wdata_q[7:0];
                    st_q   <= last_rd ? ST_STOP : ST_BYTE;
                  end
                  default: begin
                    ph_q <= PH_RDATA;
                    st_q <= ST_BYTE;
                  end
                endcase
              end
            end
          endcase
        end
        ST_RESTART: begin
          // Release data in low clock, raise clock, then START again
          if (qtr_q == 2'd0) begin
            sda_q <= 1'b1;
          end else if (qtr_q == 2'd1) begin
            scl_q <= 1'b1;
          end else if (qtr_q == 2'd3) begin
            st_q  <= ST_START;
            qtr_q <= 2'd1;
          end
        end
        ST_STOP: begin
          if (qtr_q == 2'd0) begin
            sda_q <= 1'b0;
          end else if (qtr_q == 2'd1) begin
            scl_q <= 1'b1;
          end else if (qtr_q == 2'd2) begin
            sda_q <= 1'b1;
          end else begin
            st_q   <= ST_IDLE;
            busy_q <= 1'b0;
            done_q <= 1'b1;
          end
        end
        default: begin
          qtr_q <= 2'd0;
        end
      endcase
    end
  end

  // Open drain: drive only lows, master owns the clock
  assign o_scl    = 1'b0;
  assign o_scl_oe = !scl_q;
  assign o_sda    = 1'b0;
  assign o_sda_oe = !sda_q;

  // ==========================================================
  // Checks
  chk_scl_idle_high: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (st_q == ST_IDLE) |-> !o_scl_oe && !o_sda_oe)
    else $error("Lines driven while idle");
  chk_data_stable_high: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (st_q == ST_BYTE && scl_q && $past(scl_q)) |-> $stable(sda_q))
    else $error("Data changed while clock high");
  chk_start_edge: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (st_q == ST_START && $fell(sda_q)) |-> scl_q)
    else $error("START without clock high");
  chk_stop_edge: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (st_q == ST_STOP && $rose(sda_q)) |-> scl_q)
    else $error("STOP without clock high");
  sequence s_last_ack;
    st_q == ST_ACK && ph_q == PH_RDATA && last_rd && qtr_q == 2'd2;
  endsequence
  chk_last_nack: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    s_last_ack |-> sda_q)
    else $error("Last read byte acknowledged");
  chk_ctrl_code: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (st_q == ST_BYTE && $past(st_q) == ST_START)
      |-> sh_q[7:1] == {TYPE_CODE, ctrl_q[CTRL_SEL_LSB +: 3]})
    else $error("Control byte code wrong");
  chk_nack_stop: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (st_q == ST_ACK && qtr_q == 2'd3 && nack_q && tick && !scl_wait)
      |=> st_q == ST_STOP)
    else $error("No STOP after refusal");
  chk_read_dir: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (st_q == ST_BYTE && ph_q == PH_CTRL_R && bit_q == 3'd7 && qtr_q == 2'd0)
      |-> sh_q[0])
    else $error("Read control byte lacks read bit");
endmodule : thermo_host

// *** verilog/thermo_host_pkg.sv ***
// Constants for the two-wire thermometer host controller
package thermo_host_pkg;
  // ==========================================================
  // APB register map of the controller
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_RDATA  = 8'h08;
  localparam logic [7:0] REG_WDATA  = 8'h0c;
  // ==========================================================
  // Control and status register fields
  localparam int CTRL_GO_BIT    = 0;
  localparam int CTRL_READ_BIT  = 1;
  localparam int CTRL_CMD_LSB   = 8;
  localparam int CTRL_SEL_LSB   = 16;
  localparam int CTRL_NDATA_LSB = 20;
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_NACK_BIT  = 1;
  localparam int STAT_DONE_BIT  = 2;
  // ==========================================================
  // Device side constants
  localparam logic [3:0] DEVICE_TYPE_CODE = 4'h5; // Arbitrary value, override at top
  localparam logic [7:0] CMD_FETCH_TEMP   = 8'haa;
  localparam logic [7:0] CMD_SETUP_ACCESS = 8'hac;
  localparam logic [7:0] CMD_BEGIN_CONV   = 8'hee;
  localparam logic [7:0] CMD_HALT_CONV    = 8'h22;
  localparam int CFG_DONE_BIT   = 7;
  localparam int CFG_OVER_BIT   = 6;
  localparam int CFG_UNDER_BIT  = 5;
  localparam int CFG_NVBUSY_BIT = 4;
  localparam int CFG_POL_BIT    = 1;
  localparam int CFG_SINGLE_BIT = 0;
  // ==========================================================
  // Timing: 200 MHz clock, 100 kHz standard rate
  localparam int CLK_HZ       = 200_000_000;
  localparam int SCL_HZ       = 100_000;
  localparam int QUARTER_CYC  = CLK_HZ / (SCL_HZ * 4);
  localparam int NV_WRITE_MS  = 10;
  localparam int NV_WRITE_CYC = CLK_HZ / 1000 * NV_WRITE_MS;
  localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
endpackage : thermo_host_pkg

// *** verilog/quarter_tick.sv ***
// Divider making one-cycle enable pulses at four per serial clock period
`timescale 1ns/1ps
module quarter_tick #(
  parameter int DIV = 500
) (
  input  wire logic i_clk,
  input  wire logic i_arst_n,
  input  wire logic i_run,
  output logic      o_tick
);
  import thermo_host_pkg::*;
  logic [15:0] cnt_q;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_q <= 16'h0000;
    end else if (!i_run || cnt_q == 16'(DIV - 1)) begin
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end
  assign o_tick = i_run && (cnt_q == 16'(DIV - 1));
endmodule : quarter_tick

// *** testbench/thermo_dev_model.sv ***
// Behavioural two-wire thermometer that answers the host controller
`timescale 1ns/1ps
module thermo_dev_model #(
  parameter logic [3:0]  TYPE_CODE = thermo_host_pkg::DEVICE_TYPE_CODE,
  parameter logic [15:0] TEMP      = 16'he700,
  parameter logic [7:0]  HI        = 8'h19,
  parameter logic [7:0]  LO        = 8'h00,
  parameter int          NV_NS     = 100_000
) (
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  input  wire logic [2:0] i_sel,
  input  wire logic       i_slow,
  output logic            o_scl_oe,
  output logic            o_sda_oe
);
  import thermo_host_pkg::*;
  logic       pscl, psda, on, mack, nb;
  logic [1:0] ph;
  logic [3:0] bc;
  logic [7:0] sh, cmd, tx, cfg;
  initial begin
    {pscl, psda, on, o_scl_oe, o_sda_oe} = 5'b11000;
    {cfg, cmd} = 16'h0000;
  end
  // ==========================================================
  // Serial engine, one process so start and stop never race bits
  always @(i_scl, i_sda) begin
    if (i_scl && pscl && psda && !i_sda) begin
      {on, ph, bc, o_sda_oe} = {1'b1, 2'd0, 4'd0, 1'b0};
    end else if (i_scl && pscl && !psda && i_sda) begin
      {on, o_sda_oe} = 2'b00;
    end else if (on && i_scl && !pscl) begin
      if (bc < 4'd8) sh = {sh[6:0], i_sda};
      else mack = !i_sda;
      bc = bc + 4'd1;
    end else if (on && !i_scl && pscl) begin
      if (bc == 4'd8 && ph != 2'd3) begin
        o_sda_oe = (ph != 2'd0) || (sh[7:1] == {TYPE_CODE, i_sel});
        on = o_sda_oe;
        if (i_slow && on) begin
          o_scl_oe = 1'b1;
          o_scl_oe <= #300 1'b0;
        end
        if (ph == 2'd0) begin
          ph = sh[0] ? 2'd3 : 2'd1;
          nb = 1'b0;
        end else if (ph == 2'd1) begin
          cmd = sh;
          ph = 2'd2;
          // Conversion is instant, so halt has nothing left to stop
          if (sh == CMD_BEGIN_CONV) begin
            cfg[7] = 1'b1;
            cfg[6] = cfg[6] | ($signed(TEMP[15:8]) >= $signed(HI));
            cfg[5] = cfg[5] | ($signed(TEMP[15:8]) <= $signed(LO));
          end
        end else if (cmd == CMD_SETUP_ACCESS) begin
          cfg = {cfg[7], cfg[6] & sh[6], cfg[5] & sh[5], 1'b1, 2'b00, sh[1:0]};
          cfg[4] <= #NV_NS 1'b0;
        end
      end else if (bc == 4'd8) begin
        o_sda_oe = 1'b0;
      end else if (bc == 4'd9) begin
        bc = 4'd0;
        tx = (cmd == CMD_FETCH_TEMP) ? (nb ? TEMP[7:0] : TEMP[15:8]) : cfg;
        nb = 1'b1;
        o_sda_oe = (ph == 2'd3) && mack && !tx[7];
      end else if (ph == 2'd3) begin
        o_sda_oe = !tx[7 - bc];
      end
    end
    pscl = i_scl;
    psda = i_sda;
  end
endmodule : thermo_dev_model

// *** testbench/testbench.sv ***
// Self-checking bench for the two-wire thermometer host controller
`timescale 1ns/1ps
module testbench;
  import thermo_host_pkg::*;
  logic        i_clk, i_arst_n, psel, penable, pwrite, pready, slow;
  logic        scl_oe, sda_oe, d_scl_oe, d_sda_oe, pslverr, scl_o, sda_o;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  int          errors, checked, n_start, n_stop, n_clk;
  wire         scl = !(scl_oe || d_scl_oe);
  wire         sda = !(sda_oe || d_sda_oe);

  thermo_host #(.QUARTER(4)) dut_u (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_scl(scl), .o_scl(scl_o), .o_scl_oe(scl_oe),
    .i_sda(sda), .o_sda(sda_o), .o_sda_oe(sda_oe)
  );
  // Upper limit equal to the temperature so both sticky flags get set
  thermo_dev_model #(.HI(8'he7)) dev_u (
    .i_scl(scl), .i_sda(sda), .i_sel(3'h5), .i_slow(slow),
    .o_scl_oe(d_scl_oe), .o_sda_oe(d_sda_oe)
  );

  always #2.5 i_clk = !i_clk;
  // ==========================================================
  // Wire watchers: extra edges with clock high mean bad data timing
  always @(negedge sda) if (scl) n_start++;
  always @(posedge sda) if (scl) n_stop++;
  always @(posedge scl) n_clk++;

  // ==========================================================
  // Tasks
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  task automatic give_up();
    errors++;
    $display("[FAIL] %0t wait limit reached", $time);
    complete_run();
  endtask : give_up

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge i_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    @(posedge i_clk);
    penable <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge i_clk);
      if (pready === 1'b1) break;
    end
    if (n == 50) give_up();
    rd = prdata;
    check({31'h0, pslverr}, 32'h0, "bus error response");
    {psel, penable} <= 2'b00;
  endtask : apb

  task automatic op(input logic [7:0] cmd, input logic rdb, input logic [2:0] sel,
                    input logic [1:0] n, input logic [15:0] wd, input int clks,
                    input logic nack, input logic [15:0] exp);
    int k;
    n_start = 0;
    n_stop  = 0;
    n_clk   = 0;
    apb(1'b1, REG_WDATA, {16'h0000, wd});
    apb(1'b1, REG_CTRL, {10'h000, n, 1'b0, sel, cmd, 6'h00, rdb, 1'b1});
    // Written while busy, so it must be dropped
    apb(1'b1, REG_WDATA, 32'h0000_5a5a);
    for (k = 0; k < 3000; k++) begin
      apb(1'b0, REG_STATUS, 32'h0);
      if (rd[STAT_BUSY_BIT] === 1'b0) break;
    end
    if (k == 3000) give_up();
    check({29'h0, rd[2:0]}, {29'h0, 1'b1, nack, 1'b0}, "status");
    check(n_clk, clks, "clock pulses");
    check(n_start, (rdb && n != 2'd0) ? 2 : 1, "starts");
    check(n_stop, 1, "stops");
    check({30'h0, scl, sda}, 32'h3, "idle lines");
    apb(1'b0, REG_WDATA, 32'h0);
    check(rd, {16'h0000, wd}, "write data kept");
    apb(1'b0, REG_CTRL, 32'h0);
    check(rd, {10'h000, n, 1'b0, sel, cmd, 6'h00, rdb, 1'b1}, "control readback");
    if (rdb) begin
      apb(1'b0, REG_RDATA, 32'h0);
      check({16'h0, (n == 2'd2) ? rd[15:0] : {8'h00, rd[7:0]}}, {16'h0, exp}, "read data");
    end
    $display("test command %h done", cmd);
  endtask : op

  // ==========================================================
  // Main sequence
  initial begin
    {i_clk, i_arst_n, psel, penable, pwrite, slow} = 6'b000000;
    {paddr, pwdata, errors, checked} = '0;
    repeat (8) @(posedge i_clk);
    i_arst_n <= 1'b1;
    apb(1'b0, REG_STATUS, 32'h0);
    check(rd, RESET_ZERO, "status after reset");
    check({28'h0, scl_o, sda_o, scl_oe, sda_oe}, 32'h0, "lines released");
    // Clock counts include the rise before a repeated START and before STOP
    op(CMD_SETUP_ACCESS, 1'b0, 3'h5, 2'd1, 16'h000f, 28, 1'b0, 16'h0);
    op(CMD_SETUP_ACCESS, 1'b1, 3'h5, 2'd1, 16'h0, 38, 1'b0, 16'h0013);
    op(CMD_BEGIN_CONV, 1'b0, 3'h5, 2'd0, 16'h0, 19, 1'b0, 16'h0);
    op(CMD_FETCH_TEMP, 1'b1, 3'h5, 2'd2, 16'h0, 47, 1'b0, 16'he700);
    op(CMD_SETUP_ACCESS, 1'b0, 3'h5, 2'd1, 16'h00ff, 28, 1'b0, 16'h0);
    op(CMD_SETUP_ACCESS, 1'b1, 3'h5, 2'd1, 16'h0, 38, 1'b0, 16'h00f3);
    op(CMD_SETUP_ACCESS, 1'b0, 3'h5, 2'd1, 16'h0002, 28, 1'b0, 16'h0);
    op(CMD_SETUP_ACCESS, 1'b1, 3'h5, 2'd1, 16'h0, 38, 1'b0, 16'h0092);
    slow <= 1'b1;
    op(CMD_HALT_CONV, 1'b0, 3'h5, 2'd0, 16'h0, 19, 1'b0, 16'h0);
    op(CMD_BEGIN_CONV, 1'b0, 3'h2, 2'd0, 16'h0, 10, 1'b1, 16'h0);
    apb(1'b0, 8'h10, 32'h0);
    check(rd, 32'h0, "unmapped read");
    complete_run();
  end
endmodule : testbench
